// ---- shared/sfb_pkg.sv ----
// shared types and constants for the stacked flash/ram bus control block
package sfb_pkg;

    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int CFG_W  = 16;
    localparam int LAT_W  = 4;
    localparam int NDIE   = 3;

    // read configuration layout
    localparam int CFG_WAIT_POL_BIT = 10;
    localparam int CFG_LAT_LSB      = 11;
    localparam int CFG_SYNC_BIT     = 15;

    typedef logic [ADDR_W-1:0] sfb_addr_t;
    typedef logic [DATA_W-1:0] sfb_data_t;
    typedef logic [CFG_W-1:0]  sfb_cfg_t;
    typedef logic [LAT_W-1:0]  sfb_lat_t;

    // async read array, wait asserted low, zero latency
    localparam sfb_cfg_t CFG_RESET = 16'h0000;
    localparam sfb_lat_t LAT_ZERO  = 4'h0;
    localparam sfb_lat_t LAT_ONE   = 4'h1;
    localparam sfb_addr_t ADDR_ONE = 23'h000001;

    // control pins, all low-true
    typedef struct packed {
        logic [NDIE-1:0] ceN;
        logic [1:0]      oeN;
        logic            ramOeN;
        logic            ramCsN;
        logic            weN;
        logic            ramWeN;
        logic            strobeN;
        logic            wpN;
        logic            rstN;
    } sfb_pins_t;

    localparam sfb_pins_t PINS_IDLE = '1;

endpackage : sfb_pkg

// ---- shared/sfb_link_if.sv ----
// carrier between the core-clock logic and the bus-clock logic
`timescale 1ns/1ps
interface sfb_link_if;
    import sfb_pkg::*;

    logic      syncMode;
    sfb_lat_t  latency;
    logic      latchTgl;
    sfb_addr_t latchAddr;
    logic      dataValid;

    modport core (
        output syncMode,
        output latency,
        input  latchTgl,
        input  latchAddr,
        input  dataValid
    );

    modport link (
        input  syncMode,
        input  latency,
        output latchTgl,
        output latchAddr,
        output dataValid
    );
endinterface : sfb_link_if

// ---- core/sfb_burst_link.sv ----
// bus-clock side: synchronous address latch, latency and burst counter
`timescale 1ns/1ps
module sfb_burst_link
    import sfb_pkg::*;
(
    input  wire logic      busClk,
    input  wire logic      srst,
    input  wire sfb_addr_t addrIn,
    input  wire logic      strobeN,
    input  wire logic      selN,
    output sfb_addr_t      burstAddr,
    sfb_link_if.link       lnk
);

    typedef struct packed {
        logic      rstS1;
        logic      rstS2;
        logic      modeS1;
        logic      modeS2;
        sfb_lat_t  latS1;
        sfb_lat_t  latS2;
        sfb_addr_t latchAddr;
        logic      latchTgl;
        sfb_addr_t burst;
        sfb_lat_t  waitCnt;
        logic      valid;
        logic      active;
    } sfb_link_t;

    sfb_link_t q;
    sfb_link_t n;

    ////////////////////////////////////////////////////////////////////////
    // pins here are launched by the host on this clock, so no synchroniser
    always_comb begin
        n = q;
        n.rstS1  = srst;
        n.rstS2  = q.rstS1;
        n.modeS1 = lnk.syncMode;
        n.modeS2 = q.modeS1;
        n.latS1  = lnk.latency;
        n.latS2  = q.latS1;
        if (q.rstS2 || !q.modeS2 || selN) begin
            n.active  = 1'b0;
            n.valid   = 1'b0;
            n.waitCnt = LAT_ZERO;
        end else if (!strobeN) begin
            n.latchAddr = addrIn;                             // [R8]
            n.burst     = addrIn;
            n.latchTgl  = ~q.latchTgl;
            n.waitCnt   = q.latS2;
            n.valid     = 1'b0;
            n.active    = 1'b1;
        end else if (q.active) begin
            if (q.waitCnt != LAT_ZERO) begin
                n.waitCnt = q.waitCnt - LAT_ONE;
            end else begin
                if (q.valid) begin
                    n.burst = q.burst + ADDR_ONE;             // [R7]
                end
                n.valid = 1'b1;                               // [R12]
            end
        end
        if (q.rstS2) begin
            n.latchAddr = '0;
            n.burst     = '0;
            n.latchTgl  = 1'b0;
        end
    end

    // the link clock may stop: the core side gates wait with chip select
    always_ff @(posedge busClk) begin
        q <= n;
    end

    assign burstAddr     = q.burst;
    assign lnk.latchTgl  = q.latchTgl;
    assign lnk.latchAddr = q.latchAddr;
    assign lnk.dataValid = q.valid;

endmodule : sfb_burst_link

// ---- core/sfb_bus_ctrl.sv ----
// stacked flash/ram host bus control, core clock side and top level
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// What this block does
// (R1) flash oe low enables selected die outputs
// (R2) flash oe high floats selected die outputs
// (R3) oe one: die one; oe two: dies two, three
// (R4) ram oe low drives, high floats ram
// (R5) flash address and data captured on we rise
// (R6) ram writes only through ram write strobe
// (R7) sync reads run on bus clock, burst counts
// (R8) sync latch: strobe rise or clock edge, first
// (R9) async latch at strobe rise, else flow-through
// (R10) config bit ten picks wait polarity
// (R11) wait floats when deselected, ignores oe
// (R12) sync reads: wait asserted until data valid
// (R13) async page reads and writes: wait asserted
// (R14) write protect low: lock-down holds, unlock refused
// (R15) write protect high: lock-down disabled
// (R16) deselected die: standby, data and wait float
// (R17) flash reset: async read array, operations off
module sfb_bus_ctrl
    import sfb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        busClk,
    input  wire sfb_addr_t   addrIn,
    input  wire sfb_data_t   dqIn,
    output sfb_data_t        dqOut,
    output logic             dqOe,
    input  wire sfb_data_t   arrayData,
    input  wire [NDIE-1:0]   flashCeN,
    input  wire [1:0]        flashOeN,
    input  wire logic        ramOeN,
    input  wire logic        ramCsN,
    input  wire logic        flashWeN,
    input  wire logic        ramWeN,
    input  wire logic        addrLatchStrobeN,
    input  wire logic        flashWpN,
    input  wire logic        flashRstN,
    output logic             waitOut,
    output logic             waitOe,
    output logic [NDIE-1:0]  dieOe,
    output logic [NDIE-1:0]  dieStandby,
    output logic             ramDqOe,
    input  wire logic        cfgLoad,
    input  wire sfb_cfg_t    cfgWord,
    output sfb_cfg_t         readConfigReg,
    output logic             syncMode,
    output sfb_addr_t        readAddr,
    output sfb_addr_t        burstAddr,
    output logic             flashWrite,
    output logic             ramWrite,
    output sfb_addr_t        wrAddr,
    output sfb_data_t        wrData,
    input  wire logic        unlockReq,
    input  wire logic        unlockLockedDown,
    output logic             unlockGrant,
    output logic             unlockRefused,
    output logic             lockDownOn
);

    typedef struct packed {
        sfb_pins_t       pS1;
        sfb_pins_t       pS2;
        sfb_pins_t       pS3;
        sfb_addr_t       aS1;
        sfb_addr_t       aS2;
        sfb_data_t       dS1;
        sfb_data_t       dS2;
        logic            tglS1;
        logic            tglS2;
        logic            tglS3;
        logic            vldS1;
        logic            vldS2;
        sfb_cfg_t        cfg;
        logic            held;
        sfb_addr_t       rdAddr;
        sfb_addr_t       wrAddr;
        sfb_data_t       wrData;
        sfb_data_t       dqOut;
        logic            flashWr;
        logic            ramWr;
        logic [NDIE-1:0] dieOe;
        logic [NDIE-1:0] standby;
        logic            ramOe;
        logic            dqOe;
        logic            waitLvl;
        logic            waitOe;
        logic            grant;
        logic            refused;
        logic            lockOn;
    } sfb_core_t;

    sfb_core_t q;
    sfb_core_t n;
    sfb_pins_t pinsNow;

    logic flashRun;
    logic selAny;
    logic inSync;
    logic weRise;
    logic ramWeRise;
    logic strobeRise;
    logic strobeFall;
    logic linkLatch;
    logic writing;
    logic waitAsserted;

    sfb_link_if lnk ();

    ////////////////////////////////////////////////////////////////////////
    // bus-clock logic for synchronous bursts

    sfb_burst_link u_link (
        .busClk    (busClk),
        .srst      (srst),
        .addrIn    (addrIn),
        .strobeN   (addrLatchStrobeN),
        .selN      (&flashCeN),
        .burstAddr (burstAddr),
        .lnk       (lnk.link)
    );

    assign lnk.syncMode = q.cfg[CFG_SYNC_BIT];
    assign lnk.latency  = q.cfg[CFG_LAT_LSB +: LAT_W];

    ////////////////////////////////////////////////////////////////////////
    // pin capture

    always_comb begin
        pinsNow.ceN     = flashCeN;
        pinsNow.oeN     = flashOeN;
        pinsNow.ramOeN  = ramOeN;
        pinsNow.ramCsN  = ramCsN;
        pinsNow.weN     = flashWeN;
        pinsNow.ramWeN  = ramWeN;
        pinsNow.strobeN = addrLatchStrobeN;
        pinsNow.wpN     = flashWpN;
        pinsNow.rstN    = flashRstN;
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        n = q;

        // two-stage synchronisers, third stage only for edges
        n.pS1   = pinsNow;
        n.pS2   = q.pS1;
        n.pS3   = q.pS2;
        n.aS1   = addrIn;
        n.aS2   = q.aS1;
        n.dS1   = dqIn;
        n.dS2   = q.dS1;
        n.tglS1 = lnk.latchTgl;
        n.tglS2 = q.tglS1;
        n.tglS3 = q.tglS2;
        n.vldS1 = lnk.dataValid;
        n.vldS2 = q.vldS1;

        flashRun     = q.pS2.rstN;
        selAny       = ~&q.pS2.ceN;
        inSync       = q.cfg[CFG_SYNC_BIT];
        weRise       = q.pS2.weN & ~q.pS3.weN;
        ramWeRise    = q.pS2.ramWeN & ~q.pS3.ramWeN;
        strobeRise   = q.pS2.strobeN & ~q.pS3.strobeN;
        strobeFall   = ~q.pS2.strobeN & q.pS3.strobeN;
        linkLatch    = q.tglS2 ^ q.tglS3;
        writing      = ~q.pS2.weN;

        // read mode; reset always drops back to async array reads
        if (!flashRun) begin
            n.cfg = CFG_RESET;                                // [R17]
        end else if (cfgLoad) begin
            n.cfg = cfgWord;
        end

        // output enables: die one on oe one, dies two and three on oe two
        n.dieOe[0] = flashRun & ~q.pS2.ceN[0] & ~q.pS2.oeN[0]; // [R1] [R2] [R3]
        n.dieOe[1] = flashRun & ~q.pS2.ceN[1] & ~q.pS2.oeN[1]; // [R1] [R2] [R3]
        n.dieOe[2] = flashRun & ~q.pS2.ceN[2] & ~q.pS2.oeN[1]; // [R1] [R2] [R3]
        n.standby  = q.pS2.ceN;                               // [R16]
        n.ramOe    = ~q.pS2.ramCsN & ~q.pS2.ramOeN;           // [R4]
        n.dqOe     = (|n.dieOe) | n.ramOe;                    // [R16]
        n.dqOut    = arrayData;

        // flash write: address and data taken at the strobe's rise
        n.flashWr = weRise & selAny & flashRun;               // [R5] [R17]
        if (n.flashWr) begin
            n.wrAddr = q.aS2;                                 // [R5]
            n.wrData = q.dS2;                                 // [R5]
        end

        // ram accepts a write only on its own strobe
        n.ramWr = ramWeRise & ~q.pS2.ramCsN;                  // [R6]
        if (n.ramWr) begin
            n.wrAddr = q.aS2;                                 // [R6]
            n.wrData = q.dS2;                                 // [R6]
        end

        // address latch
        if (!inSync) begin
            n.held = 1'b0;
            if (!q.pS2.strobeN || strobeRise) begin
                n.rdAddr = q.aS2;                             // [R9]
            end
        end else begin
            if (strobeFall) begin
                n.held = 1'b0;
            end
            // link word is stable: it only changes on the next strobe low
            if (linkLatch && !n.held) begin
                n.rdAddr = lnk.latchAddr;                     // [R8]
                n.held   = 1'b1;
            end else if (strobeRise && !n.held) begin
                n.rdAddr = q.aS2;                             // [R8]
                n.held   = 1'b1;
            end
        end

        // wait: asserted for async reads, writes, and until data valid
        if (inSync) begin
            waitAsserted = ~q.vldS2 | writing;                // [R12] [R13]
        end else begin
            waitAsserted = 1'b1;                              // [R13]
        end
        if (q.cfg[CFG_WAIT_POL_BIT]) begin
            n.waitLvl = waitAsserted;                         // [R10]
        end else begin
            n.waitLvl = ~waitAsserted;                        // [R10]
        end
        // drive follows chip select and flash reset, never output enable
        n.waitOe = selAny & flashRun;                         // [R11] [R16]

        // lock-down follows write protect; refusal stays high for as long as the request is held
        n.lockOn  = ~q.pS2.wpN;                               // [R14] [R15]
        n.grant   = unlockReq & flashRun
                    & (~unlockLockedDown | q.pS2.wpN);         // [R15]
        n.refused = unlockReq & flashRun
                    & unlockLockedDown & ~q.pS2.wpN;           // [R14]

        if (srst) begin
            n       = '0;
            n.pS1   = PINS_IDLE;
            n.pS2   = PINS_IDLE;
            n.pS3   = PINS_IDLE;
            n.cfg   = CFG_RESET;
            n.standby = '1;
        end
    end

    always_ff @(posedge clk) begin
        q <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops

    assign dqOut         = q.dqOut;
    assign dqOe          = q.dqOe;
    assign waitOut       = q.waitLvl;
    assign waitOe        = q.waitOe;
    assign dieOe         = q.dieOe;
    assign dieStandby    = q.standby;
    assign ramDqOe       = q.ramOe;
    assign readConfigReg = q.cfg;
    assign syncMode      = q.cfg[CFG_SYNC_BIT];
    assign readAddr      = q.rdAddr;
    assign flashWrite    = q.flashWr;
    assign ramWrite      = q.ramWr;
    assign wrAddr        = q.wrAddr;
    assign wrData        = q.wrData;
    assign unlockGrant   = q.grant;
    assign unlockRefused = q.refused;
    assign lockDownOn    = q.lockOn;

endmodule : sfb_bus_ctrl

// ---- tb/sfb_bus_ctrl_checker.sv ----
// assertions on the pins of the stacked flash/ram bus control block
`timescale 1ns/1ps
module sfb_bus_ctrl_checker
    import sfb_pkg::*;
(
    input wire logic            clk,
    input wire logic            srst,
    input wire logic [NDIE-1:0] flashCeN,
    input wire logic [1:0]      flashOeN,
    input wire logic            flashWeN,
    input wire logic            flashWpN,
    input wire logic            flashRstN,
    input wire sfb_data_t       dqIn,
    input wire logic            unlockReq,
    input wire logic            unlockLockedDown,
    input wire logic            waitOut,
    input wire logic            waitOe,
    input wire logic [NDIE-1:0] dieOe,
    input wire sfb_cfg_t        readConfigReg,
    input wire logic            syncMode,
    input wire logic            flashWrite,
    input wire sfb_data_t       wrData,
    input wire logic            unlockGrant,
    input wire logic            unlockRefused,
    input wire logic            lockDownOn
);
    logic [2:0] upCnt_q;
    logic       rdy;
    // $past looks 4 back, so wait until that history is past reset
    always_ff @(posedge clk) begin
        if (srst) upCnt_q <= 3'h0;
        else if (!rdy) upCnt_q <= upCnt_q + 3'h1;
    end
    assign rdy = upCnt_q == 3'h7;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (srst);
////////////////////////////////////////////////////////////////////////////
    die_one_oe_a: assert property (rdy |->
        dieOe[0] == $past(!flashCeN[0] && !flashOeN[0] && flashRstN, 3)) else $error("oe one");
    die_three_oe_a: assert property (rdy |->
        dieOe[2] == $past(!flashCeN[2] && !flashOeN[1] && flashRstN, 3)) else $error("oe two");
    wait_float_a: assert property (rdy && $past(&flashCeN, 3) |-> !waitOe)
        else $error("wait driven while deselected");
    async_wait_a: assert property (rdy && waitOe && !syncMode && $stable(syncMode) &&
        $stable(readConfigReg) |-> waitOut == readConfigReg[CFG_WAIT_POL_BIT]) else $error("wait");
    lock_level_a: assert property (rdy |-> lockDownOn == $past(!flashWpN, 3))
        else $error("lock-down level");
    unlock_refuse_a: assert property (rdy && unlockReq && unlockLockedDown &&
        !$past(flashWpN, 2) && $past(flashRstN, 2) |=> unlockRefused && !unlockGrant)
        else $error("unlock");
    flash_write_a: assert property (rdy && $past(flashWeN, 3) && !$past(flashWeN, 4) &&
        $past(flashRstN && !(&flashCeN), 3) |-> flashWrite && wrData == $past(dqIn, 3))
        else $error("flash write capture");
    reset_off_a: assert property (rdy && !$past(flashRstN, 3) |-> dieOe == 3'h0 && !waitOe)
        else $error("reset left outputs on");
    cover property (flashWrite);
    cover property (unlockRefused);
    cover property (syncMode && waitOe);
endmodule : sfb_bus_ctrl_checker

bind sfb_bus_ctrl sfb_bus_ctrl_checker chk (.*);

// ---- tb/sfb_host_model.sv ----
// host memory controller model driving the device's control pins
`timescale 1ns/1ps
module sfb_host_model
    import sfb_pkg::*;
(
    input wire logic        clk,
    output logic            busClk,
    output sfb_addr_t       addrIn,
    output sfb_data_t       dqIn,
    output logic [NDIE-1:0] flashCeN,
    output logic [1:0]      flashOeN,
    output logic            ramOeN,
    output logic            ramCsN,
    output logic            flashWeN,
    output logic            ramWeN,
    output logic            addrLatchStrobeN
);
    initial begin
        {busClk, addrIn, dqIn} = '0;
        {flashCeN, flashOeN, ramOeN, ramCsN, flashWeN, ramWeN, addrLatchStrobeN} = '1;
    end
    // every level stands 4 clk, one more than the pin sync needs
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold
    task automatic sel(input logic [NDIE-1:0] ce, input logic [1:0] oe, input logic ro, rc);
        flashCeN = ce;
        flashOeN = oe;
        ramOeN = ro;
        ramCsN = rc;
        hold(4);
    endtask : sel
    task automatic drive(input sfb_addr_t a, input logic stb);
        addrIn = a;
        addrLatchStrobeN = stb;
        hold(4);
    endtask : drive
    task automatic write(input logic ram, input sfb_addr_t a, input sfb_data_t d);
        addrIn = a;
        dqIn = d;
        if (ram) ramWeN = 1'b0;
        else flashWeN = 1'b0;
        hold(4);
        {ramWeN, flashWeN} = 2'b11;
        hold(4);
        dqIn = ~d; // released bus no longer shows the last word
    endtask : write
    // bus clock runs only when a burst or the link reset wants it
    task automatic clocks(input int n);
        repeat (n) begin
            #16 busClk = 1'b1;
            #16 busClk = 1'b0;
        end
        hold(1);
    endtask : clocks
endmodule : sfb_host_model

// ---- tb/sfb_bus_ctrl_bench.sv ----
// self-checking bench for the stacked flash/ram bus control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin testsRun++; if ((s) !== (e)) begin nFail++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module sfb_bus_ctrl_bench
    import sfb_pkg::*;
;
    logic clk, busClk, srst, flashWpN, flashRstN, cfgLoad, unlockReq, unlockLockedDown;
    logic ramOeN, ramCsN, flashWeN, ramWeN, addrLatchStrobeN, dqOe, waitOut, waitOe;
    logic ramDqOe, syncMode, flashWrite, ramWrite, unlockGrant, unlockRefused, lockDownOn;
    logic [NDIE-1:0] flashCeN, dieOe, dieStandby;
    logic [1:0]      flashOeN;
    sfb_addr_t       addrIn, readAddr, burstAddr, wrAddr;
    sfb_data_t       dqIn, dqOut, arrayData, wrData;
    sfb_cfg_t        cfgWord, readConfigReg;
    int              nFail = 0, testsRun = 0, nFw = 0, nRw = 0, nGr = 0, nRf = 0;
    sfb_bus_ctrl   dut  (.*);
    sfb_host_model host (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // pulses are counted here; the checker times flashWrite and unlockRefused, but not ramWrite or unlockGrant
    always @(posedge clk) begin
        nFw <= nFw + int'(flashWrite);
        nRw <= nRw + int'(ramWrite);
        nGr <= nGr + int'(unlockGrant);
        nRf <= nRf + int'(unlockRefused);
    end
////////////////////////////////////////////////////////////////////////////
    task automatic setCfg(input sfb_cfg_t c);
        cfgWord = c;
        cfgLoad = 1'b1;
        host.hold(1);
        cfgLoad = 1'b0;
        host.hold(3);
        `CHK("cfg", c, readConfigReg)
    endtask : setCfg
    task automatic tOutEnable();
        for (int i = 0; i < NDIE; i++) begin
            arrayData = ~arrayData;
            host.sel(~(3'h1 << i), (i == 0) ? 2'h2 : 2'h1, 1'b1, 1'b1);
            `CHK("dieOe", 3'h1 << i, dieOe)
            `CHK("dqOe", 1'b1, dqOe)
            `CHK("dqOut", arrayData, dqOut)
            `CHK("standby", ~(3'h1 << i), dieStandby)
            host.sel(~(3'h1 << i), 2'h3, 1'b1, 1'b1);
            `CHK("dieOeOff", 3'h0, dieOe)
        end
        host.sel(3'h6, 2'h1, 1'b0, 1'b0);
        `CHK("oeCross", 3'h0, dieOe)
        `CHK("ramOe", 1'b1, ramDqOe)
        host.sel(3'h7, 2'h3, 1'b1, 1'b0);
        `CHK("ramOeOff", 1'b0, ramDqOe)
    endtask : tOutEnable
    task automatic tWrite();
        host.sel(3'h5, 2'h3, 1'b1, 1'b0);
        host.write(1'b0, 23'h7fffff, 16'ha55a);
        `CHK("flashWr", 1, nFw)
        `CHK("wrAddr", 23'h7fffff, wrAddr)
        `CHK("wrData", 16'ha55a, wrData)
        host.write(1'b1, 23'h000155, 16'hbeef);
        `CHK("ramWr", 1, nRw)
        `CHK("ramData", 16'hbeef, wrData)
        host.sel(3'h7, 2'h3, 1'b1, 1'b1);
        host.write(1'b0, 23'h000001, 16'h0001);
        host.write(1'b1, 23'h000002, 16'h0002);
        `CHK("deselWr", 2, nFw + nRw)
    endtask : tWrite
    task automatic tAsync();
        host.sel(3'h6, 2'h3, 1'b1, 1'b1);
        `CHK("waitOn", 1'b1, waitOe)
        `CHK("waitLow", 1'b0, waitOut)
        setCfg(16'h0400);
        `CHK("waitHigh", 1'b1, waitOut)
        host.drive(23'h0000a1, 1'b0);
        `CHK("flowA", 23'h0000a1, readAddr)
        host.drive(23'h0000a2, 1'b0);
        `CHK("flowB", 23'h0000a2, readAddr)
        host.drive(23'h0000a2, 1'b1);
        host.drive(23'h0000a3, 1'b1);
        `CHK("held", 23'h0000a2, readAddr)
        host.sel(3'h7, 2'h3, 1'b1, 1'b1);
        `CHK("waitOff", 1'b0, waitOe)
    endtask : tAsync
    task automatic tSync();
        setCfg(16'h9400);
        host.sel(3'h6, 2'h2, 1'b1, 1'b1);
        host.clocks(3);
        host.drive(23'h000100, 1'b0);
        host.clocks(1);
        host.drive(23'h0001ff, 1'b1); // a late rise must not override the clock latch
        `CHK("syncAddr", 23'h000100, readAddr)
        `CHK("waitBusy", 1'b1, waitOut)
        host.clocks(6);
        host.hold(4);
        `CHK("waitDone", 1'b0, waitOut)
        `CHK("burst", 23'h000103, burstAddr)
        host.sel(3'h7, 2'h3, 1'b1, 1'b1);
        host.clocks(2);
        `CHK("syncFloat", 1'b0, waitOe)
    endtask : tSync
    task automatic tLock();
        unlockLockedDown = 1'b1;
        for (int w = 0; w < 2; w++) begin
            flashWpN = w[0];
            host.hold(4);
            `CHK("lockOn", ~w[0], lockDownOn)
            unlockReq = 1'b1;
            host.hold(1);
            unlockReq = 1'b0;
            host.hold(3);
            `CHK("refused", 1, nRf)
            `CHK("granted", w, nGr)
        end
        unlockLockedDown = 1'b0;
        flashWpN = 1'b0;
        host.hold(4);
        unlockReq = 1'b1;
        host.hold(1);
        unlockReq = 1'b0;
        host.hold(3);
        `CHK("plainGrant", 2, nGr)
        `CHK("plainRefuse", 1, nRf)
    endtask : tLock
    task automatic tReset();
        setCfg(16'h9400);
        host.sel(3'h6, 2'h2, 1'b1, 1'b1);
        flashRstN = 1'b0;
        host.hold(4);
        `CHK("rstOe", 3'h0, dieOe)
        `CHK("rstWait", 1'b0, waitOe)
        host.write(1'b0, 23'h000003, 16'h0003);
        `CHK("rstWr", 1, nFw)
        flashRstN = 1'b1;
        host.hold(4);
        `CHK("rstCfg", CFG_RESET, readConfigReg)
        `CHK("rstBack", 3'h1, dieOe)
    endtask : tReset
////////////////////////////////////////////////////////////////////////////
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : giveVerdict
    initial begin
        repeat (8000) @(posedge clk);
        nFail++;
        giveVerdict();
    end
    initial begin
        srst = 1'b1;
        {flashWpN, flashRstN, cfgLoad, unlockReq, unlockLockedDown} = 5'h18;
        arrayData = 16'h1234;
        cfgWord = CFG_RESET;
        fork
            host.clocks(3); // link reset crosses on bus clock edges
        join_none
        host.hold(6);
        srst = 1'b0;
        host.hold(4);
        `CHK("cfgRst", CFG_RESET, readConfigReg)
        tOutEnable();
        tWrite();
        tAsync();
        tSync();
        tLock();
        tReset();
        giveVerdict();
    end
endmodule : sfb_bus_ctrl_bench
